// ===== pdmrc_cfg.svh
`ifndef PDMRC_CFG_SVH
`define PDMRC_CFG_SVH

// Register byte addresses
`define PDMRC_CTL_OFFSET 16'h1a40
`define PDMRC_RESET_CONTROL_REGISTER_OFFSET 16'h1a50
`define PDMRC_STATUS_OFFSET 16'h1a54

// Receiver control register fields
`define PDMRC_CTL_CABLE_DETECT_BIT 0
`define PDMRC_CTL_FIFO_FORMAT_BIT 1
`define PDMRC_CTL_REPLY_TIMER_BIT 2
`define PDMRC_CTL_RX_RESET_BIT 3
`define PDMRC_CTL_RX_ENABLE_BIT 4
`define PDMRC_CTL_LOOPBACK_BIT 5
`define PDMRC_CTL_WRITE_MASK 8'h3f
`define PDMRC_CTL_RESET 8'h00

// Reset control register fields
`define PDMRC_RST_SOFTWARE_BIT 0
`define PDMRC_RST_PROTOCOL_BIT 1
`define PDMRC_RST_CTL_RESET 2'h0

// Status register fields
`define PDMRC_STAT_TIMEOUT_BIT 0
`define PDMRC_STAT_RX_LIVE_BIT 1
`define PDMRC_STAT_ARMED_BIT 2
`define PDMRC_STAT_TIMER_RUN_BIT 3
`define PDMRC_STAT_TIMER_EXP_BIT 4

// Reply timer period
`define PDMRC_CLOCK_PERIOD_NS 8
`define PDMRC_REPLY_TIME_NS 1000
`define PDMRC_REPLY_CYCLES ((`PDMRC_REPLY_TIME_NS + `PDMRC_CLOCK_PERIOD_NS - 1) / `PDMRC_CLOCK_PERIOD_NS)

`endif

// ===== pdmrc_pkg.sv
package pdmrc_pkg;

  typedef enum logic [1:0]
  {
    PDMRC_TIMER_IDLE = 2'b00,
    PDMRC_TIMER_LOADED = 2'b01,
    PDMRC_TIMER_RUNNING = 2'b10,
    PDMRC_TIMER_EXPIRED = 2'b11
  } pdmrc_timer_state_type;

endpackage

// ===== pdmrc_receiver_control.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`include "pdmrc_cfg.svh"

module pdmrc_receiver_control
#(
  parameter int P_ADDR_WIDTH = 16,
  parameter int P_RETRY_WIDTH = 2,
  parameter int P_TIMER_WIDTH = 16,
  parameter int P_REPLY_CYCLES = `PDMRC_REPLY_CYCLES
)
(
  input wire logic i_clock, // System clock, 125 MHz
  input wire logic i_resetn, // Asynchronous reset, active low
  input wire logic i_wb_cyc, // Wishbone cycle
  input wire logic i_wb_stb, // Wishbone strobe
  input wire logic i_wb_we, // Wishbone write enable
  input wire logic [P_ADDR_WIDTH-1:0] i_wb_adr, // Wishbone byte address
  input wire logic [3:0] i_wb_sel, // Wishbone byte selects
  input wire logic [31:0] i_wb_dat, // Wishbone write data
  output logic [31:0] o_wb_dat, // Wishbone read data
  output logic o_wb_ack, // Wishbone acknowledge
  input wire logic i_rx_active, // Receiver is inside a packet
  input wire logic i_tx_active, // Transmitter is driving the line
  input wire logic i_hard_reset_seen, // Hard Reset signalling received, pulse
  input wire logic i_cable_reset_seen, // Cable Reset signalling received, pulse
  input wire logic i_tx_start, // Packet transmission begins, pulse
  input wire logic i_tx_end, // Packet transmission ends, pulse
  input wire logic i_goodcrc_seen, // GoodCRC message received, pulse
  input wire logic i_auto_response_enable, // Auto-response mode from transmit control
  input wire logic i_wait_for_reply, // Wait-for-reply option from transmit control
  input wire logic [P_RETRY_WIDTH-1:0] i_retry_count, // Retry count from transmit control
  output logic o_loopback_enable, // Closes the loop at the line pin
  output logic o_rx_line_enable, // Receiver may sample the line
  output logic o_receiver_active, // Effective receiver enable
  output logic o_receive_queue_reset, // Holds receive queue in reset
  output logic o_hard_reset_detect, // Hard Reset recognition enabled
  output logic o_cable_reset_detect, // Cable Reset recognition enabled
  output logic o_fifo_length_first, // Read FIFO layout select
  output logic o_reply_timer_expired, // Reply timer in expired state
  output logic o_reply_timeout_flag, // Sticky reply timeout flag
  output logic o_reply_timeout_event // Reply timer expired, pulse
);

  generate
    if (P_ADDR_WIDTH < 16 || P_ADDR_WIDTH > 32)
    begin : g_bad_addr
      $error("address width must be 16 to 32");
    end
    if (P_RETRY_WIDTH < 1 || P_RETRY_WIDTH > 8)
    begin : g_bad_retry
      $error("retry width must be 1 to 8");
    end
    if (P_TIMER_WIDTH < 2 || P_TIMER_WIDTH > 30)
    begin : g_bad_timer
      $error("timer width must be 2 to 30");
    end
    if (P_REPLY_CYCLES < 1 || P_REPLY_CYCLES >= (1 << P_TIMER_WIDTH))
    begin : g_bad_cycles
      $error("reply cycles do not fit the timer");
    end
  endgenerate

  localparam logic [P_TIMER_WIDTH-1:0] LP_RELOAD = P_TIMER_WIDTH'(P_REPLY_CYCLES);
  localparam logic [P_TIMER_WIDTH-1:0] LP_ONE = P_TIMER_WIDTH'(1);

  function automatic logic addr_hit(input logic [P_ADDR_WIDTH-1:0] adr, input logic [15:0] offset);
    addr_hit = (adr == P_ADDR_WIDTH'(offset));
  endfunction

  logic [7:0] control;
  logic protocol_reset;
  logic receiver_live;
  logic detect_armed;
  logic timeout_flag;
  logic timeout_event;
  logic [P_TIMER_WIDTH-1:0] timer_count;
  pdmrc_pkg::pdmrc_timer_state_type timer_state;
  pdmrc_pkg::pdmrc_timer_state_type next_timer_state;
  logic [P_TIMER_WIDTH-1:0] next_timer_count;
  logic [31:0] next_read_data;
  logic [7:0] next_control;

  logic bus_req;
  logic bus_write;
  logic wr_ctl;
  logic wr_rst;
  logic wr_stat;
  logic software_reset;
  logic reset_signalling;
  logic timer_on;
  logic timer_expire;
  logic auto_timer;
  logic [7:0] status_byte;

  // Single-cycle answer: ack rises the cycle after the request and drops next
  assign bus_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign bus_write = bus_req & i_wb_we & i_wb_sel[0];
  assign wr_ctl = bus_write & addr_hit(i_wb_adr, `PDMRC_CTL_OFFSET);
  assign wr_rst = bus_write & addr_hit(i_wb_adr, `PDMRC_RESET_CONTROL_REGISTER_OFFSET);
  assign wr_stat = bus_write & addr_hit(i_wb_adr, `PDMRC_STATUS_OFFSET);
  assign software_reset = wr_rst & i_wb_dat[`PDMRC_RST_SOFTWARE_BIT];

  // Detection is gated until the first enable after reset
  assign reset_signalling = detect_armed &
    (i_hard_reset_seen | (i_cable_reset_seen & control[`PDMRC_CTL_CABLE_DETECT_BIT]));

  assign auto_timer = (i_auto_response_enable & (i_retry_count != '0)) |
    (i_wait_for_reply & (i_retry_count == '0));
  assign timer_on = control[`PDMRC_CTL_REPLY_TIMER_BIT] | auto_timer;
  assign timer_expire = (timer_state == pdmrc_pkg::PDMRC_TIMER_RUNNING) && (timer_count == LP_ONE);

  always_comb
  begin
    next_control = control;
    if (wr_ctl)
    begin
      next_control = i_wb_dat[7:0] & `PDMRC_CTL_WRITE_MASK;
    end
    if (reset_signalling)
    begin
      next_control[`PDMRC_CTL_RX_ENABLE_BIT] = 1'b0;
    end
  end

  // Protocol reset does not touch this register; power-on and software reset clear it, reset signalling clears the enable bit
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      control <= `PDMRC_CTL_RESET;
    end
    else if (software_reset)
    begin
      control <= `PDMRC_CTL_RESET;
    end
    else
    begin
      control <= next_control;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      protocol_reset <= 1'b0;
    end
    else if (software_reset)
    begin
      protocol_reset <= 1'b0;
    end
    else if (wr_rst)
    begin
      protocol_reset <= i_wb_dat[`PDMRC_RST_PROTOCOL_BIT];
    end
  end

  // Arming survives every later clear of the enable bit except a power-on or software reset, which drops it
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      detect_armed <= 1'b0;
    end
    else if (software_reset)
    begin
      detect_armed <= 1'b0;
    end
    else if (control[`PDMRC_CTL_RX_ENABLE_BIT])
    begin
      detect_armed <= 1'b1;
    end
  end

  // The live copy only follows the bit between packets
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      receiver_live <= 1'b0;
    end
    else if (software_reset)
    begin
      receiver_live <= 1'b0;
    end
    else if (!i_rx_active)
    begin
      receiver_live <= control[`PDMRC_CTL_RX_ENABLE_BIT];
    end
  end

  always_comb
  begin
    next_timer_state = timer_state;
    next_timer_count = timer_count;
    case (timer_state)
      pdmrc_pkg::PDMRC_TIMER_IDLE:
      begin
        if (i_tx_start && timer_on)
        begin
          next_timer_state = pdmrc_pkg::PDMRC_TIMER_LOADED;
          next_timer_count = LP_RELOAD;
        end
      end
      pdmrc_pkg::PDMRC_TIMER_LOADED:
      begin
        if (!timer_on)
        begin
          next_timer_state = pdmrc_pkg::PDMRC_TIMER_IDLE;
        end
        else if (i_tx_end)
        begin
          next_timer_state = pdmrc_pkg::PDMRC_TIMER_RUNNING;
        end
      end
      pdmrc_pkg::PDMRC_TIMER_RUNNING:
      begin
        if (!timer_on || (i_goodcrc_seen && auto_timer))
        begin
          next_timer_state = pdmrc_pkg::PDMRC_TIMER_IDLE;
        end
        else if (i_tx_start)
        begin
          next_timer_state = pdmrc_pkg::PDMRC_TIMER_LOADED;
          next_timer_count = LP_RELOAD;
        end
        else if (timer_expire)
        begin
          next_timer_state = pdmrc_pkg::PDMRC_TIMER_EXPIRED;
        end
        else
        begin
          next_timer_count = timer_count - LP_ONE;
        end
      end
      pdmrc_pkg::PDMRC_TIMER_EXPIRED:
      begin
        if (i_tx_start)
        begin
          next_timer_state = timer_on ? pdmrc_pkg::PDMRC_TIMER_LOADED : pdmrc_pkg::PDMRC_TIMER_IDLE;
          next_timer_count = LP_RELOAD;
        end
      end
      default:
      begin
        next_timer_state = pdmrc_pkg::PDMRC_TIMER_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timer_state <= pdmrc_pkg::PDMRC_TIMER_IDLE;
      timer_count <= '0;
    end
    else if (software_reset || protocol_reset)
    begin
      timer_state <= pdmrc_pkg::PDMRC_TIMER_IDLE;
      timer_count <= '0;
    end
    else
    begin
      timer_state <= next_timer_state;
      timer_count <= next_timer_count;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timeout_event <= 1'b0;
    end
    else
    begin
      timeout_event <= timer_expire && !software_reset && !protocol_reset &&
        (next_timer_state == pdmrc_pkg::PDMRC_TIMER_EXPIRED);
    end
  end

  // A new expiry beats a simultaneous write-one-to-clear
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timeout_flag <= 1'b0;
    end
    else if (software_reset)
    begin
      timeout_flag <= 1'b0;
    end
    else if (timeout_event)
    begin
      timeout_flag <= 1'b1;
    end
    else if (wr_stat && i_wb_dat[`PDMRC_STAT_TIMEOUT_BIT])
    begin
      timeout_flag <= 1'b0;
    end
  end

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`PDMRC_STAT_TIMEOUT_BIT] = timeout_flag;
    status_byte[`PDMRC_STAT_RX_LIVE_BIT] = receiver_live;
    status_byte[`PDMRC_STAT_ARMED_BIT] = detect_armed;
    status_byte[`PDMRC_STAT_TIMER_RUN_BIT] = (timer_state == pdmrc_pkg::PDMRC_TIMER_RUNNING);
    status_byte[`PDMRC_STAT_TIMER_EXP_BIT] = (timer_state == pdmrc_pkg::PDMRC_TIMER_EXPIRED);
  end

  always_comb
  begin
    next_read_data = 32'h0000_0000;
    if (addr_hit(i_wb_adr, `PDMRC_CTL_OFFSET))
    begin
      next_read_data[7:0] = control & `PDMRC_CTL_WRITE_MASK;
    end
    else if (addr_hit(i_wb_adr, `PDMRC_RESET_CONTROL_REGISTER_OFFSET))
    begin
      next_read_data[`PDMRC_RST_PROTOCOL_BIT] = protocol_reset;
    end
    else if (addr_hit(i_wb_adr, `PDMRC_STATUS_OFFSET))
    begin
      next_read_data[7:0] = status_byte;
    end
  end

  // Unmapped addresses are acknowledged, read zero and drop writes
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end
    else
    begin
      o_wb_ack <= bus_req;
      if (bus_req && !i_wb_we)
      begin
        o_wb_dat <= next_read_data;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_loopback_enable <= 1'b0;
      o_rx_line_enable <= 1'b1;
      o_receive_queue_reset <= 1'b0;
      o_hard_reset_detect <= 1'b0;
      o_cable_reset_detect <= 1'b0;
      o_fifo_length_first <= 1'b0;
    end
    else
    begin
      // The switch sits at the shared pad so loopback exercises the analog path
      o_loopback_enable <= control[`PDMRC_CTL_LOOPBACK_BIT];
      o_rx_line_enable <= ~i_tx_active | control[`PDMRC_CTL_LOOPBACK_BIT];
      o_receive_queue_reset <= control[`PDMRC_CTL_RX_RESET_BIT] | protocol_reset;
      o_hard_reset_detect <= detect_armed;
      o_cable_reset_detect <= detect_armed & control[`PDMRC_CTL_CABLE_DETECT_BIT];
      o_fifo_length_first <= control[`PDMRC_CTL_FIFO_FORMAT_BIT];
    end
  end

  always_comb
  begin
    o_receiver_active = receiver_live & ~o_receive_queue_reset;
    o_reply_timer_expired = (timer_state == pdmrc_pkg::PDMRC_TIMER_EXPIRED);
    o_reply_timeout_flag = timeout_flag;
    o_reply_timeout_event = timeout_event;
  end

endmodule

// ===== pdmrc_receiver_control_assertions.sv
`timescale 1ns/100ps
module pdmrc_receiver_control_checker
#(
  parameter int P_ADDR_WIDTH = 16
)
(
  input wire logic i_clock, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic i_wb_cyc, // Bus cycle
  input wire logic i_wb_stb, // Bus strobe
  input wire logic i_wb_we, // Bus write
  input wire logic [P_ADDR_WIDTH-1:0] i_wb_adr, // Bus address
  input wire logic [3:0] i_wb_sel, // Byte selects
  input wire logic [31:0] i_wb_dat, // Write data
  input wire logic [31:0] o_wb_dat, // Read data
  input wire logic o_wb_ack, // Acknowledge
  input wire logic i_tx_start, // Transmission start
  input wire logic o_loopback_enable, // Loopback
  input wire logic o_receiver_active, // Receiver live
  input wire logic o_receive_queue_reset, // Queue reset
  input wire logic o_hard_reset_detect, // Hard reset detect
  input wire logic o_cable_reset_detect, // Cable reset detect
  input wire logic o_fifo_length_first, // FIFO layout
  input wire logic o_reply_timer_expired, // Timer expired
  input wire logic o_reply_timeout_flag, // Timeout flag
  input wire logic o_reply_timeout_event // Timeout pulse
);
  logic wr_ctl;
  assign wr_ctl = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0] && i_wb_adr == 16'h1a40;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  loopback_copy_a: assert property (wr_ctl |-> ##2 o_loopback_enable == $past(i_wb_dat[5], 2))
    else $error("loopback output does not follow control write");
  queue_reset_a: assert property (wr_ctl && i_wb_dat[3] |-> ##2 o_receive_queue_reset)
    else $error("receive queue not held in reset");
  fifo_layout_a: assert property (wr_ctl |-> ##2 o_fifo_length_first == $past(i_wb_dat[1], 2))
    else $error("fifo layout does not follow control write");
  detect_sticky_a: assert property (o_hard_reset_detect && !i_wb_cyc |=> o_hard_reset_detect)
    else $error("reset detection dropped without software reset");
  cable_detect_a: assert property (o_cable_reset_detect |-> o_hard_reset_detect)
    else $error("cable detection enabled before first enable");
  queue_blocks_a: assert property (o_receive_queue_reset |-> !o_receiver_active)
    else $error("receiver active while held in reset");
  expired_hold_a: assert property (o_reply_timer_expired && !i_tx_start && !(i_wb_cyc && i_wb_we)
    |=> o_reply_timer_expired)
    else $error("expired timer left expired state early");
  timeout_flag_a: assert property (o_reply_timeout_event |-> o_reply_timer_expired ##1 o_reply_timeout_flag)
    else $error("timeout event without expiry and flag");
  event_single_a: assert property (o_reply_timeout_event |=> !o_reply_timeout_event)
    else $error("timeout event longer than one cycle");
  reserved_zero_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr == 16'h1a40 |-> o_wb_dat[7:6] == 2'h0)
    else $error("reserved control bits read nonzero");
endmodule

bind pdmrc_receiver_control pdmrc_receiver_control_checker #(.P_ADDR_WIDTH(P_ADDR_WIDTH)) chk_u
(
  .i_clock, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
  .o_wb_ack, .i_tx_start, .o_loopback_enable, .o_receiver_active, .o_receive_queue_reset,
  .o_hard_reset_detect, .o_cable_reset_detect, .o_fifo_length_first, .o_reply_timer_expired,
  .o_reply_timeout_flag, .o_reply_timeout_event
);

// ===== pdmrc_port_partner.sv
`timescale 1ns/100ps
module pdmrc_port_partner
(
  input wire logic i_clock, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic i_go, // Start one action, pulse
  input wire logic [1:0] i_cmd, // 0 packet, 1 hard, 2 cable, 3 GoodCRC
  output logic o_rx_active, // Packet on the line
  output logic o_hard_reset_seen, // Hard reset pulse
  output logic o_cable_reset_seen, // Cable reset pulse
  output logic o_goodcrc_seen // GoodCRC pulse
);
  logic [3:0] left;
  assign o_rx_active = left != 4'h0;
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      left <= 4'h0;
      o_hard_reset_seen <= 1'b0;
      o_cable_reset_seen <= 1'b0;
      o_goodcrc_seen <= 1'b0;
    end
    else
    begin
      o_hard_reset_seen <= i_go && i_cmd == 2'h1;
      o_cable_reset_seen <= i_go && i_cmd == 2'h2;
      o_goodcrc_seen <= i_go && i_cmd == 2'h3;
      if (i_go && i_cmd == 2'h0)
        left <= 4'h6;
      else if (left != 4'h0)
        left <= left - 4'h1;
    end
  end
endmodule

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
  typedef struct {logic [15:0] a; logic [7:0] d; logic ta; logic [7:0] rd; logic lb; logic ff; logic le;} pdmrc_row_type;
  logic i_clock = 1'b0;
  logic i_resetn = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [15:0] i_wb_adr = 16'h0000;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0000_0000;
  logic i_tx_active = 1'b0;
  logic i_tx_start = 1'b0;
  logic i_tx_end = 1'b0;
  logic i_auto_response_enable = 1'b0;
  logic i_wait_for_reply = 1'b0;
  logic [1:0] i_retry_count = 2'h0;
  logic go = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack, i_rx_active, i_hard_reset_seen, i_cable_reset_seen, i_goodcrc_seen, o_loopback_enable;
  logic o_rx_line_enable, o_receiver_active, o_receive_queue_reset, o_hard_reset_detect, o_cable_reset_detect;
  logic o_fifo_length_first, o_reply_timer_expired, o_reply_timeout_flag, o_reply_timeout_event;
  int miscompares = 0;
  int n_tests = 0;
  int n_events = 0;
  logic [7:0] q;
  pdmrc_row_type rows [5] = '{
    '{16'h1a40, 8'hff, 1'b1, 8'h3f, 1'b1, 1'b1, 1'b1},
    '{16'h1a40, 8'h20, 1'b1, 8'h20, 1'b1, 1'b0, 1'b1},
    '{16'h1a40, 8'h02, 1'b1, 8'h02, 1'b0, 1'b1, 1'b0},
    '{16'h1a48, 8'hff, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1},
    '{16'h1a50, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1}};

  // Short reply time keeps the timer scenarios brief
  pdmrc_receiver_control #(.P_REPLY_CYCLES(8)) dut_u
  (
    .i_clock, .i_resetn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat,
    .o_wb_ack, .i_rx_active, .i_tx_active, .i_hard_reset_seen, .i_cable_reset_seen, .i_tx_start,
    .i_tx_end, .i_goodcrc_seen, .i_auto_response_enable, .i_wait_for_reply, .i_retry_count,
    .o_loopback_enable, .o_rx_line_enable, .o_receiver_active, .o_receive_queue_reset,
    .o_hard_reset_detect, .o_cable_reset_detect, .o_fifo_length_first, .o_reply_timer_expired,
    .o_reply_timeout_flag, .o_reply_timeout_event
  );
  pdmrc_port_partner partner_u
  (
    .i_clock, .i_resetn, .i_go(go), .i_cmd(cmd), .o_rx_active(i_rx_active),
    .o_hard_reset_seen(i_hard_reset_seen), .o_cable_reset_seen(i_cable_reset_seen),
    .o_goodcrc_seen(i_goodcrc_seen)
  );

  initial
  begin
    forever #4 i_clock = ~i_clock;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // Ack is sampled at the edge itself, so the release lands right after it
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= {24'h00_0000, d};
    i_wb_sel <= 4'h1;
    n = 0;
    do
    begin
      @(posedge i_clock);
      n++;
    end
    while (o_wb_ack !== 1'b1 && n < 20);
    if (o_wb_ack !== 1'b1)
    begin
      miscompares++;
      tally_and_finish();
    end
    else
    begin
      r = o_wb_dat[7:0];
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
    end
  endtask

  task automatic partner(input logic [1:0] c);
    @(posedge i_clock);
    cmd <= c;
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Every expiry pulse is counted so a doubled or missing pulse shows up
  always @(posedge i_clock)
  begin
    if (o_reply_timeout_event === 1'b1)
      n_events <= n_events + 1;
  end

  task automatic send_frame();
    start_pulse();
    tick(2);
    i_tx_end <= 1'b1;
    @(posedge i_clock);
    i_tx_end <= 1'b0;
  endtask

  task automatic start_pulse();
    @(posedge i_clock);
    i_tx_start <= 1'b1;
    @(posedge i_clock);
    i_tx_start <= 1'b0;
  endtask

  initial
  begin
    tick(5);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    chk("line enable", 8'h01, o_rx_line_enable);
    bus(1'b0, 16'h1a40, 8'h00, q);
    chk("control reset", 8'h00, q);
    chk("cable detect", 8'h00, o_cable_reset_detect);
    foreach (rows[i])
    begin
      i_tx_active <= rows[i].ta;
      bus(1'b1, rows[i].a, rows[i].d, q);
      bus(1'b0, rows[i].a, 8'h00, q);
      chk("readback", rows[i].rd, q);
      chk("loopback", rows[i].lb, o_loopback_enable);
      chk("fifo layout", rows[i].ff, o_fifo_length_first);
      chk("line enable", rows[i].le, o_rx_line_enable);
    end
    bus(1'b0, 16'h1a54, 8'h00, q);
    chk("armed after soft reset", 8'h00, q & 8'h06);
    partner(2'h1);
    tick(3);
    chk("hard detect idle", 8'h00, o_hard_reset_detect);
    partner(2'h0);
    bus(1'b1, 16'h1a40, 8'h10, q);
    chk("active in packet", 8'h00, o_receiver_active);
    tick(6);
    chk("active after packet", 8'h01, o_receiver_active);
    chk("hard detect armed", 8'h01, o_hard_reset_detect);
    partner(2'h1);
    tick(3);
    bus(1'b0, 16'h1a40, 8'h00, q);
    chk("enable cleared", 8'h00, q);
    chk("hard detect kept", 8'h01, o_hard_reset_detect);
    bus(1'b1, 16'h1a40, 8'h11, q);
    tick(2);
    chk("cable detect", 8'h01, o_cable_reset_detect);
    partner(2'h2);
    tick(2);
    bus(1'b0, 16'h1a40, 8'h00, q);
    chk("cable clears enable", 8'h01, q);
    bus(1'b1, 16'h1a40, 8'h18, q);
    tick(2);
    chk("queue reset", 8'h01, o_receive_queue_reset);
    chk("active in reset", 8'h00, o_receiver_active);
    bus(1'b1, 16'h1a40, 8'h10, q);
    tick(2);
    chk("queue released", 8'h00, o_receive_queue_reset);
    bus(1'b1, 16'h1a50, 8'h02, q);
    tick(2);
    chk("protocol reset", 8'h01, o_receive_queue_reset);
    bus(1'b0, 16'h1a40, 8'h00, q);
    chk("enable kept", 8'h10, q);
    bus(1'b1, 16'h1a50, 8'h00, q);
    // Modes: software bit, auto with retries, wait with no retry, none
    for (int m = 0; m < 4; m++)
    begin
      i_auto_response_enable <= (m == 1);
      i_wait_for_reply <= (m == 2);
      i_retry_count <= (m == 1) ? 2'h1 : 2'h0;
      bus(1'b1, 16'h1a40, (m == 0) ? 8'h04 : 8'h00, q);
      send_frame();
      tick(12);
      chk("expired", {7'h00, m != 3}, o_reply_timer_expired);
      bus(1'b0, 16'h1a54, 8'h00, q);
      chk("timeout flag", {7'h00, m != 3}, {7'h00, q[0]});
      chk("flag port", {7'h00, m != 3}, o_reply_timeout_flag);
      bus(1'b1, 16'h1a54, 8'h01, q);
      chk("flag cleared", 8'h00, o_reply_timeout_flag);
      bus(1'b1, 16'h1a40, 8'h00, q);
      i_auto_response_enable <= 1'b0;
      i_wait_for_reply <= 1'b0;
      start_pulse();
      tick(1);
      chk("expired after start", 8'h00, o_reply_timer_expired);
    end
    // GoodCRC stops the timer in auto mode; in software mode software drops the reply timer bit
    i_auto_response_enable <= 1'b1;
    i_retry_count <= 2'h1;
    send_frame();
    partner(2'h3);
    tick(12);
    chk("auto goodcrc stop", 8'h00, o_reply_timer_expired);
    i_auto_response_enable <= 1'b0;
    i_retry_count <= 2'h0;
    bus(1'b1, 16'h1a40, 8'h04, q);
    send_frame();
    partner(2'h3);
    bus(1'b1, 16'h1a40, 8'h00, q);
    tick(12);
    chk("software goodcrc stop", 8'h00, o_reply_timer_expired);
    chk("timeout events", 8'h03, n_events[7:0]);
    // Second reset in mid-run: arming and control return to their reset state
    i_resetn <= 1'b0;
    tick(2);
    i_resetn <= 1'b1;
    @(posedge i_clock);
    chk("detect after reset", 8'h00, o_hard_reset_detect);
    chk("line after reset", 8'h01, o_rx_line_enable);
    bus(1'b0, 16'h1a40, 8'h00, q);
    chk("control after reset", 8'h00, q);
    tally_and_finish();
  end
endmodule
